/* shared/xcfr_pkg.sv */
// Constants and types of the check-framed command responder.
//**********************************************************************
// Notes on behaviour
// - Every frame starts with the start control character 0x02.
// - Text ends with end control character 0x03, then two check characters.
// - Frame text holds at most 120 characters.
// - Check is XOR of all characters from start through end character, seeded zero.
// - Check goes out as two ASCII hex characters, upper nibble first.
// - Identifier is always three ASCII decimal digits, zero padded on the left.
// - Data request with own identifier or none returns the concentration reply; the code drops one that arrives while a reply is still going out.
// - Mode letters M, N and K select measure, zero and span mode.
// - Mode letter S starts a forced background check.
// - Single reply: header, count 01, space separated fields, fillers, space before end.
// - Dual reply: count 02 plus a second identifier, concentration, status, failure group.
// - Request without identifier omits it, except dual replies always carry both.
// - Status bit 0 zero, bit 1 out of service, bit 2 zero, bit 3 span.
// - Status bit 6 is one for volumetric units, zero for gravimetric.
// - Status bit 7 is set while in background mode.
// - Failure bits: 0 flow, 1 instrument, 3 lamp, 5 cell heater, positive logic.
//**********************************************************************
package xcfr_pkg;

   //*******************************************************************
   // Characters
   //*******************************************************************
   localparam logic [7:0] XCFR_STX      = 8'h02;
   localparam logic [7:0] XCFR_ETX      = 8'h03;
   localparam logic [7:0] XCFR_SPACE    = 8'h20;
   localparam logic [7:0] XCFR_ZERO     = 8'h30;
   localparam logic [7:0] XCFR_ONE      = 8'h31;
   localparam logic [7:0] XCFR_TWO      = 8'h32;
   localparam logic [7:0] XCFR_CH_A     = 8'h41;
   localparam logic [7:0] XCFR_CH_D     = 8'h44;
   localparam logic [7:0] XCFR_CH_K     = 8'h4B;
   localparam logic [7:0] XCFR_CH_M     = 8'h4D;
   localparam logic [7:0] XCFR_CH_N     = 8'h4E;
   localparam logic [7:0] XCFR_CH_S     = 8'h53;
   localparam logic [7:0] XCFR_CH_T     = 8'h54;
   localparam logic [7:0] XCFR_MAX_TEXT = 8'h78;
   localparam logic [7:0] XCFR_LEN_NOID = 8'h02;
   localparam logic [7:0] XCFR_LEN_ID   = 8'h05;
   localparam logic [7:0] XCFR_LEN_SET  = 8'h07;

   //*******************************************************************
   // Reply layout positions
   //*******************************************************************
   localparam logic [6:0] XCFR_P_COUNT  = 7'h04;
   localparam logic [6:0] XCFR_P_ID     = 7'h06;
   localparam logic [6:0] XCFR_P_CONC   = 7'h0A;
   localparam logic [6:0] XCFR_P_SS     = 7'h13;
   localparam logic [6:0] XCFR_P_FF     = 7'h16;
   localparam logic [6:0] XCFR_P_FILL   = 7'h19;
   localparam logic [6:0] XCFR_P_GRP2   = 7'h23;
   localparam logic [6:0] XCFR_GRP2_OFS = 7'h1D;
   localparam logic [6:0] XCFR_P_SP2END = 7'h3E;
   localparam logic [6:0] XCFR_P_ETX1   = 7'h23;
   localparam logic [6:0] XCFR_P_ETX2   = 7'h3F;

   //*******************************************************************
   // Registers
   //*******************************************************************
   localparam logic [3:0]  XCFR_REG_CTRL   = 4'h0;
   localparam logic [3:0]  XCFR_REG_STATUS = 4'h4;
   localparam int          XCFR_CTRL_DUAL  = 12;
   localparam int          XCFR_CTRL_VOL   = 13;
   localparam int          XCFR_CTRL_NO2   = 14;
   localparam logic [14:0] XCFR_CTRL_RESET = 15'h0000;
   localparam int          XCFR_SS_OOS     = 1;
   localparam int          XCFR_SS_ZERO    = 2;
   localparam int          XCFR_SS_SPAN    = 3;
   localparam int          XCFR_SS_UNITS   = 6;
   localparam int          XCFR_SS_BKG     = 7;
   localparam int          XCFR_FF_FLOW    = 0;
   localparam int          XCFR_FF_INSTR   = 1;
   localparam int          XCFR_FF_LAMP    = 3;
   localparam int          XCFR_FF_HEATER  = 5;

   //*******************************************************************
   // Types
   //*******************************************************************
   typedef enum logic [1:0]
   {
      RX_IDLE   = 2'b00,
      RX_TEXT   = 2'b01,
      RX_CHK_HI = 2'b10,
      RX_CHK_LO = 2'b11
   } xcfr_rx_state_type;

   typedef enum logic [1:0]
   {
      MODE_MEASURE = 2'b00,
      MODE_ZERO    = 2'b01,
      MODE_SPAN    = 2'b10
   } xcfr_mode_type;

   typedef struct packed
   {
      logic [7:0][7:0] primary;
      logic [7:0][7:0] secondary;
      logic            out_of_service;
      logic            background;
      logic            flow_fault;
      logic            instr_fault;
      logic            lamp_fault;
      logic            heater_fault;
   } xcfr_meas_type;

   typedef struct packed
   {
      xcfr_rx_state_type rx_state;
      logic [7:0]        rx_len;
      logic [7:0]        rx_xor;
      logic [6:0][7:0]   rx_text;
      logic [7:0]        rx_hi;
      xcfr_mode_type     mode;
      logic              bkg_start;
      logic              tx_busy;
      logic [6:0]        tx_pos;
      logic              tx_with_id;
      logic              tx_dual;
      logic [7:0]        tx_xor;
      logic [7:0]        tx_data;
      logic              tx_valid;
      xcfr_meas_type     snap;
      logic [7:0]        snap_ss;
      logic [14:0]       ctrl;
      logic [31:0]       rd_data;
      logic [7:0]        good_cnt;
      logic [7:0]        drop_cnt;
   } xcfr_state_type;

endpackage // xcfr_pkg

/* design/xcfr_responder.sv */
// Check-framed command receiver, mode control and concentration reply framer.
//
// Our own choices: the plain strobed port and the register offsets.
module xcfr_responder
   import xcfr_pkg::*;
(
   input  wire logic          i_sys_clk,
   input  wire logic          i_reset_n,
   input  wire logic [7:0]    i_rx_data,
   input  wire logic          i_rx_valid,
   output logic      [7:0]    o_tx_data,
   output logic               o_tx_valid,
   input  wire logic          i_tx_ready,
   input  wire xcfr_meas_type i_meas,
   output logic               o_zero_mode,
   output logic               o_span_mode,
   output logic               o_bkg_start,
   output logic               o_second_is_dioxide,
   input  wire logic [3:0]    i_reg_addr,
   input  wire logic [31:0]   i_reg_wdata,
   input  wire logic          i_reg_wr,
   input  wire logic          i_reg_rd,
   output logic      [31:0]   o_reg_rdata
);

   //*******************************************************************
   // Helpers
   //*******************************************************************
   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'hA) ? (XCFR_ZERO + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   function automatic logic [7:0] group_char(input logic [6:0] q,
                                             input logic [11:0] id,
                                             input logic [7:0][7:0] conc,
                                             input logic [7:0] ss,
                                             input logic [7:0] ff);
      logic [6:0] k;
      logic [7:0] c;
      k = 7'h00;
      c = XCFR_SPACE;
      if (q >= XCFR_P_ID && q < XCFR_P_ID + 7'h03)
      begin
         k = q - XCFR_P_ID;
         c = {4'h3, id[4'(4'd8 - 4'(k) * 4'd4) +: 4]};
      end
      else if (q >= XCFR_P_CONC && q < XCFR_P_CONC + 7'h08)
      begin
         k = q - XCFR_P_CONC;
         c = conc[3'(3'd7 - k[2:0])];
      end
      else if (q == XCFR_P_SS)
         c = hex_char(ss[7:4]);
      else if (q == XCFR_P_SS + 7'h01)
         c = hex_char(ss[3:0]);
      else if (q == XCFR_P_FF)
         c = hex_char(ff[7:4]);
      else if (q == XCFR_P_FF + 7'h01)
         c = hex_char(ff[3:0]);
      else if (q >= XCFR_P_FILL && q < XCFR_P_FILL + 7'h09)
         c = XCFR_ZERO;
      return c;
   endfunction

   //*******************************************************************
   // State
   //*******************************************************************
   xcfr_state_type s_q;
   xcfr_state_type s_d;

   logic [7:0] s_ff;
   logic [7:0] s_char;
   logic [6:0] s_next_pos;
   logic [6:0] s_last_pos;
   logic       s_check_pos;
   logic       s_id_match;
   logic       s_frame_ok;
   logic       s_is_da;
   logic       s_is_st;
   logic       s_da_id;
   logic       s_da_noid;
   logic [7:0] s_live_ss;

   always_comb
   begin
      s_d = s_q;
      s_d.bkg_start = 1'b0;

      s_ff = 8'h00;
      s_ff[XCFR_FF_FLOW]   = s_q.snap.flow_fault;
      s_ff[XCFR_FF_INSTR]  = s_q.snap.instr_fault;
      s_ff[XCFR_FF_LAMP]   = s_q.snap.lamp_fault;
      s_ff[XCFR_FF_HEATER] = s_q.snap.heater_fault;

      // Status byte taken live so it snapshots with the reply start.
      s_live_ss = 8'h00;
      s_live_ss[XCFR_SS_OOS]   = i_meas.out_of_service;
      s_live_ss[XCFR_SS_ZERO]  = (s_q.mode == MODE_ZERO);
      s_live_ss[XCFR_SS_SPAN]  = (s_q.mode == MODE_SPAN);
      s_live_ss[XCFR_SS_UNITS] = s_q.ctrl[XCFR_CTRL_VOL];
      s_live_ss[XCFR_SS_BKG]   = i_meas.background;

      //****************************************************************
      // Reply character at the current position
      //****************************************************************
      s_last_pos  = s_q.tx_dual ? XCFR_P_ETX2 + 7'h02 : XCFR_P_ETX1 + 7'h02;
      s_check_pos = (s_q.tx_pos > s_last_pos - 7'h02);
      s_next_pos  = s_q.tx_pos + 7'h01;
      if (!s_q.tx_with_id && s_q.tx_pos == XCFR_P_ID - 7'h01)
         s_next_pos = XCFR_P_CONC;
      if (s_q.tx_pos == 7'h00)
         s_char = XCFR_STX;
      else if (s_q.tx_pos == 7'h01)
         s_char = XCFR_CH_M;
      else if (s_q.tx_pos == 7'h02)
         s_char = XCFR_CH_D;
      else if (s_q.tx_pos == 7'h03)
         s_char = XCFR_ZERO;
      else if (s_q.tx_pos == XCFR_P_COUNT)
         s_char = s_q.tx_dual ? XCFR_TWO : XCFR_ONE;
      else if (s_q.tx_pos == s_last_pos - 7'h02)
         s_char = XCFR_ETX;
      else if (s_q.tx_pos == s_last_pos - 7'h01)
         s_char = hex_char(s_q.tx_xor[7:4]);
      else if (s_q.tx_pos == s_last_pos)
         s_char = hex_char(s_q.tx_xor[3:0]);
      else if (s_q.tx_dual && s_q.tx_pos == XCFR_P_SP2END)
         s_char = XCFR_SPACE;
      else if (s_q.tx_dual && s_q.tx_pos >= XCFR_P_GRP2)
         s_char = group_char(s_q.tx_pos - XCFR_GRP2_OFS, s_q.ctrl[11:0], s_q.snap.secondary,
                             s_q.snap_ss, s_ff);
      else
         s_char = group_char(s_q.tx_pos, s_q.ctrl[11:0], s_q.snap.primary, s_q.snap_ss, s_ff);

      if (s_q.tx_valid && i_tx_ready)
         s_d.tx_valid = 1'b0;
      if (s_q.tx_busy && (!s_q.tx_valid || i_tx_ready))
      begin
         if (s_q.tx_pos > s_last_pos)
            s_d.tx_busy = 1'b0;
         else
         begin
            s_d.tx_data  = s_char;
            s_d.tx_valid = 1'b1;
            s_d.tx_pos   = s_next_pos;
            if (!s_check_pos)
               s_d.tx_xor = s_q.tx_xor ^ s_char;
         end
      end

      //****************************************************************
      // Receive
      //****************************************************************
      s_id_match = (s_q.rx_text[2] == {4'h3, s_q.ctrl[11:8]}) &&
                   (s_q.rx_text[3] == {4'h3, s_q.ctrl[7:4]}) &&
                   (s_q.rx_text[4] == {4'h3, s_q.ctrl[3:0]});
      s_frame_ok = (s_q.rx_hi == hex_char(s_q.rx_xor[7:4])) &&
                   (i_rx_data == hex_char(s_q.rx_xor[3:0])) &&
                   (s_q.rx_len <= XCFR_MAX_TEXT);
      s_is_da    = (s_q.rx_text[0] == XCFR_CH_D) && (s_q.rx_text[1] == XCFR_CH_A);
      s_da_noid  = s_is_da && (s_q.rx_len == XCFR_LEN_NOID);
      s_da_id    = s_is_da && (s_q.rx_len == XCFR_LEN_ID) && s_id_match;
      s_is_st    = (s_q.rx_text[0] == XCFR_CH_S) && (s_q.rx_text[1] == XCFR_CH_T) &&
                   (s_q.rx_len == XCFR_LEN_SET) && s_id_match &&
                   (s_q.rx_text[5] == XCFR_SPACE);

      if (i_rx_valid)
      begin
         if (i_rx_data == XCFR_STX)
         begin
            // A start character always resynchronises, even mid-frame.
            s_d.rx_state = RX_TEXT;
            s_d.rx_len   = 8'h00;
            s_d.rx_xor   = XCFR_STX;
         end
         else
         begin
            unique case (s_q.rx_state)
               RX_IDLE: s_d.rx_state = RX_IDLE;
               RX_TEXT:
               begin
                  if (i_rx_data == XCFR_ETX)
                  begin
                     s_d.rx_xor   = s_q.rx_xor ^ XCFR_ETX;
                     s_d.rx_state = RX_CHK_HI;
                  end
                  else
                  begin
                     s_d.rx_xor = s_q.rx_xor ^ i_rx_data;
                     if (s_q.rx_len < 8'h07)
                        s_d.rx_text[3'(s_q.rx_len)] = i_rx_data;
                     if (s_q.rx_len <= XCFR_MAX_TEXT)
                        s_d.rx_len = s_q.rx_len + 8'h01;
                  end
               end
               RX_CHK_HI:
               begin
                  s_d.rx_hi    = i_rx_data;
                  s_d.rx_state = RX_CHK_LO;
               end
               RX_CHK_LO:
               begin
                  s_d.rx_state = RX_IDLE;
                  if (s_frame_ok && (s_da_noid || s_da_id) && !s_q.tx_busy)
                  begin
                     s_d.good_cnt   = s_q.good_cnt + 8'h01;
                     s_d.tx_busy    = 1'b1;
                     s_d.tx_pos     = 7'h00;
                     s_d.tx_xor     = 8'h00;
                     s_d.tx_dual    = s_q.ctrl[XCFR_CTRL_DUAL];
                     s_d.tx_with_id = s_da_id || s_q.ctrl[XCFR_CTRL_DUAL];
                     s_d.snap       = i_meas;
                     s_d.snap_ss    = s_live_ss;
                  end
                  else if (s_frame_ok && s_is_st &&
                           (s_q.rx_text[6] inside {XCFR_CH_M, XCFR_CH_N, XCFR_CH_K, XCFR_CH_S}))
                  begin
                     s_d.good_cnt = s_q.good_cnt + 8'h01;
                     if (s_q.rx_text[6] == XCFR_CH_M)
                        s_d.mode = MODE_MEASURE;
                     else if (s_q.rx_text[6] == XCFR_CH_N)
                        s_d.mode = MODE_ZERO;
                     else if (s_q.rx_text[6] == XCFR_CH_K)
                        s_d.mode = MODE_SPAN;
                     else
                        s_d.bkg_start = 1'b1;
                  end
                  else
                     s_d.drop_cnt = s_q.drop_cnt + 8'h01;
               end
            endcase
         end
      end

      //****************************************************************
      // Register port
      //****************************************************************
      s_d.rd_data = 32'h0000_0000;
      if (i_reg_wr && i_reg_addr == XCFR_REG_CTRL)
         s_d.ctrl = i_reg_wdata[14:0];
      if (i_reg_rd)
      begin
         if (i_reg_addr == XCFR_REG_CTRL)
            s_d.rd_data = {17'h0_0000, s_q.ctrl};
         else if (i_reg_addr == XCFR_REG_STATUS)
            s_d.rd_data = {s_q.good_cnt, s_q.drop_cnt, 5'h00, s_q.tx_busy, s_q.mode, 8'h00};
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         s_q      <= '0;
         s_q.ctrl <= XCFR_CTRL_RESET;
      end
      else
         s_q <= s_d;
   end

   //*******************************************************************
   // Outputs
   //*******************************************************************
   assign o_tx_data           = s_q.tx_data;
   assign o_tx_valid          = s_q.tx_valid;
   assign o_zero_mode         = (s_q.mode == MODE_ZERO);
   assign o_span_mode         = (s_q.mode == MODE_SPAN);
   assign o_bkg_start         = s_q.bkg_start;
   assign o_second_is_dioxide = s_q.ctrl[XCFR_CTRL_NO2];
   assign o_reg_rdata         = s_q.rd_data;

endmodule // xcfr_responder

/* verif/xcfr_host_model.sv */
// Host model: sends command frames and accepts reply characters.
module xcfr_host_model
   import xcfr_pkg::*;
(
   input  wire logic       i_sys_clk,
   output logic      [7:0] o_rx_data,
   output logic            o_rx_valid,
   output logic            o_tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic slow = 1'b0;
   initial o_rx_valid = 1'b0;
   initial o_rx_data = 8'h00;
   initial o_tx_ready = 1'b1;
   // A slow host stalls most reply characters to test holding.
   always @(posedge i_sys_clk) o_tx_ready <= !slow || ($urandom_range(3) == 0);

   function automatic logic [7:0] hexc(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction

   // A nonzero flip spoils the check.
   task automatic send_frame(input logic [7:0] txt[$], input logic [7:0] flip);
      logic [7:0] f[$];
      logic [7:0] x;
      f = {XCFR_STX, txt, XCFR_ETX};
      x = flip;
      foreach (f[k]) x ^= f[k];
      f.push_back(hexc(x[7:4]));
      f.push_back(hexc(x[3:0]));
      @(posedge i_sys_clk);
      foreach (f[k])
      begin
         o_rx_data  <= f[k];
         o_rx_valid <= 1'b1;
         @(posedge i_sys_clk);
      end
      o_rx_valid <= 1'b0;
      o_rx_data  <= ~f[f.size() - 1];
   endtask
endmodule // xcfr_host_model

/* verif/xcfr_responder_sva.sv */
// Assertions on the responder ports.
module xcfr_responder_sva
   import xcfr_pkg::*;
(
   input wire logic        i_sys_clk,
   input wire logic        i_reset_n,
   input wire logic        i_rx_valid,
   input wire logic [7:0]  o_tx_data,
   input wire logic        o_tx_valid,
   input wire logic        i_tx_ready,
   input wire logic        o_zero_mode,
   input wire logic        o_span_mode,
   input wire logic        o_bkg_start,
   input wire logic        o_second_is_dioxide,
   input wire logic [3:0]  i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic        i_reg_wr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   wire logic  acc = o_tx_valid && i_tx_ready;
   logic       in_text_q;
   logic [1:0] tail_q;
   logic [7:0] xor_q;
   logic [7:0] len_q;

   function automatic logic [7:0] hexc(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction

   always_ff @(posedge i_sys_clk or negedge i_reset_n)
      if (!i_reset_n)
      begin
         in_text_q <= 1'b0;
         tail_q    <= 2'h0;
         xor_q     <= 8'h00;
         len_q     <= 8'h00;
      end
      else if (acc)
      begin
         if (tail_q != 2'h0)
            tail_q <= tail_q - 2'h1;
         else if (!in_text_q)
            in_text_q <= 1'b1;
         else if (o_tx_data == XCFR_ETX)
         begin
            in_text_q <= 1'b0;
            tail_q    <= 2'h2;
         end
         else
            len_q <= len_q + 8'h01;
         if (tail_q == 2'h0)
            xor_q <= in_text_q ? xor_q ^ o_tx_data : o_tx_data;
         if (tail_q == 2'h0 && !in_text_q)
            len_q <= 8'h00;
      end

   property p_first_stx;
      acc && tail_q == 2'h0 && !in_text_q |-> o_tx_data == XCFR_STX;
   endproperty
   a_first_stx: assert property (p_first_stx) else $error("no start char");
   property p_hold;
      o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data);
   endproperty
   a_hold: assert property (p_hold) else $error("char not held");
   property p_len;
      acc && in_text_q && o_tx_data == XCFR_ETX |-> len_q <= XCFR_MAX_TEXT;
   endproperty
   a_len: assert property (p_len) else $error("text too long");
   property p_chk_hi;
      acc && tail_q == 2'h2 |-> o_tx_data == hexc(xor_q[7:4]);
   endproperty
   a_chk_hi: assert property (p_chk_hi) else $error("bad check high");
   property p_chk_lo;
      acc && tail_q == 2'h1 |-> o_tx_data == hexc(xor_q[3:0]);
   endproperty
   a_chk_lo: assert property (p_chk_lo) else $error("bad check low");
   property p_modes;
      o_bkg_start |-> $stable({o_zero_mode, o_span_mode});
   endproperty
   a_modes: assert property (p_modes) else $error("mode moved on bkg start");
   property p_mode_cause;
      $changed({o_zero_mode, o_span_mode}) |-> $past(i_rx_valid) || $past(i_rx_valid, 2);
   endproperty
   a_mode_cause: assert property (p_mode_cause) else $error("stray mode change");
   property p_bkg;
      o_bkg_start |-> ($past(i_rx_valid) || $past(i_rx_valid, 2)) ##1 !o_bkg_start;
   endproperty
   a_bkg: assert property (p_bkg) else $error("stray bkg pulse");
   property p_dioxide;
      i_reg_wr && i_reg_addr == XCFR_REG_CTRL |=> o_second_is_dioxide == $past(i_reg_wdata[XCFR_CTRL_NO2]);
   endproperty
   a_dioxide: assert property (p_dioxide) else $error("dioxide bit not written");
endmodule // xcfr_responder_sva

bind xcfr_responder xcfr_responder_sva i_sva (.i_sys_clk, .i_reset_n, .i_rx_valid, .o_tx_data, .o_tx_valid,
   .i_tx_ready, .o_zero_mode, .o_span_mode, .o_bkg_start, .o_second_is_dioxide, .i_reg_addr, .i_reg_wdata,
   .i_reg_wr);

/* verif/testbench.sv */
// Self-checking bench for the responder.
module testbench;
   import xcfr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] data_request_cmd = {XCFR_CH_D, XCFR_CH_A};
   localparam logic [15:0] set_mode_cmd     = {XCFR_CH_S, XCFR_CH_T};
   logic          clk = 1'b0;
   logic          reset_n = 1'b0;
   logic [7:0]    rx_data, tx_data, ex;
   logic          rx_valid, tx_valid, tx_ready, zero_mode, span_mode, bkg_start, dioxide;
   logic          reg_wr = 1'b0;
   logic          reg_rd = 1'b0;
   logic          rd_d = 1'b0;
   logic [3:0]    reg_addr = 4'h0;
   logic [31:0]   reg_wdata = 32'h0, reg_rdata;
   xcfr_meas_type meas = '0;
   logic [7:0]    exp_q[$], long_q[$];
   logic [31:0]   rexp_q[$], rmask_q[$];
   logic [11:0]   id = 12'h097;
   logic          zexp = 1'b0;
   logic          sexp = 1'b0;
   logic [7:0]    letters[4] = '{XCFR_CH_N, XCFR_CH_K, XCFR_CH_S, XCFR_CH_M};
   int            mismatches = 0;
   int            n_tests = 0;
   int            bkg_n = 0;

   always #12.5 clk = ~clk;
   xcfr_host_model i_host (.i_sys_clk(clk), .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_tx_ready(tx_ready));
   xcfr_responder i_dut (.i_sys_clk(clk), .i_reset_n(reset_n), .i_rx_data(rx_data), .i_rx_valid(rx_valid),
      .o_tx_data(tx_data), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready), .i_meas(meas), .o_zero_mode(zero_mode),
      .o_span_mode(span_mode), .o_bkg_start(bkg_start), .o_second_is_dioxide(dioxide), .i_reg_addr(reg_addr),
      .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata));

   //*****************************************************************
   // Shared tasks
   //*****************************************************************
   task automatic check(input string what, input logic [31:0] e, got);
      n_tests++;
      if (got !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic ep(input logic [7:0] c);
      exp_q.push_back(c);
      ex ^= c;
   endtask
   task automatic eph(input logic [7:0] b);
      ep(i_host.hexc(b[7:4]));
      ep(i_host.hexc(b[3:0]));
   endtask
   task automatic group(input logic show_id, input logic [7:0][7:0] conc, input logic [7:0] ss, ff, input int zeros);
      if (show_id)
      begin
         for (int k = 2; k >= 0; k--) ep(XCFR_ZERO + 8'(id[k*4 +: 4]));
         ep(XCFR_SPACE);
      end
      for (int k = 7; k >= 0; k--) ep(conc[k]);
      ep(XCFR_SPACE);
      eph(ss);
      ep(XCFR_SPACE);
      eph(ff);
      ep(XCFR_SPACE);
      repeat (zeros) ep(XCFR_ZERO);
      ep(XCFR_SPACE);
   endtask
   task automatic expect_reply(input logic with_id, input logic dual, input logic vol);
      logic [7:0]      ss;
      logic [7:0]      ff;
      logic [5:0][7:0] h;
      ss = {meas.background, vol, 2'b00, sexp, zexp, meas.out_of_service, 1'b0};
      ff = {2'b00, meas.heater_fault, 1'b0, meas.lamp_fault, 1'b0, meas.instr_fault, meas.flow_fault};
      h = {XCFR_STX, XCFR_CH_M, XCFR_CH_D, XCFR_ZERO, dual ? XCFR_TWO : XCFR_ONE, XCFR_SPACE};
      ex = 8'h00;
      for (int k = 5; k >= 0; k--) ep(h[k]);
      group(with_id || dual, meas.primary, ss, ff, 9);
      if (dual)
         group(1'b1, meas.secondary, ss, ff, 8);
      ep(XCFR_ETX);
      eph(ex);
   endtask
   task automatic send_cmd(input logic [15:0] cmd, input logic with_id, input logic [7:0] letter, flip);
      logic [7:0] q[$];
      q = {cmd[15:8], cmd[7:0]};
      if (with_id)
         for (int k = 2; k >= 0; k--) q.push_back(XCFR_ZERO + 8'(id[k*4 +: 4]));
      if (letter != 8'h00)
         q = {q, XCFR_SPACE, letter};
      i_host.send_frame(q, flip);
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic reg_read(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      rexp_q.push_back(e & m);
      rmask_q.push_back(m);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask
   // Bounded, so a reply that never ends cannot hang the run.
   task automatic drain;
      int k;
      k = 0;
      while (exp_q.size() != 0 && k < 3000)
      begin
         @(posedge clk);
         k++;
      end
      check("reply_done", 32'h0, 32'(exp_q.size()));
      repeat (4) @(posedge clk);
   endtask
   task automatic new_meas;
      xcfr_meas_type m;
      m = '0;
      for (int k = 0; k < 8; k++)
      begin
         m.primary[k]   = XCFR_ZERO + 8'($urandom_range(9));
         m.secondary[k] = XCFR_ZERO + 8'($urandom_range(9));
      end
      {m.out_of_service, m.background, m.flow_fault, m.instr_fault, m.lamp_fault, m.heater_fault} = 6'($urandom());
      meas <= m;
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   //*****************************************************************
   // Watchers and main sequence
   //*****************************************************************
   always @(posedge clk)
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         if (exp_q.size() == 0)
            check("tx_unexpected", 32'h0, {24'h0, tx_data});
         else
            check("tx_data", {24'h0, exp_q.pop_front()}, {24'h0, tx_data});
   always @(posedge clk) rd_d <= reg_rd;
   always @(negedge clk)
      if (rd_d)
         check("reg_rdata", rexp_q.pop_front(), reg_rdata & rmask_q.pop_front());
   always @(posedge clk)
      if (bkg_start === 1'b1)
         bkg_n++;
   initial
   begin
      #500000;
      check("watchdog", 32'h0, 32'h1);
      print_verdict();
   end
   initial
   begin
      void'($urandom(80575));
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      reg_read(XCFR_REG_CTRL, 32'h0, 32'hFFFFFFFF);
      reg_read(4'hC, 32'h0, 32'hFFFFFFFF);
      for (int t = 0; t < 4; t++)
      begin
         new_meas();
         i_host.slow <= t[0];
         reg_write(XCFR_REG_CTRL, {17'h0, t[1], t[0], t[1], id});
         send_cmd(data_request_cmd, t[0], 8'h00, 8'h00);
         expect_reply(t[0], t[1], t[0]);
         drain();
         check("second_is_dioxide", 32'(t[1]), {31'h0, dioxide});
      end
      reg_write(XCFR_REG_CTRL, {20'h0, id});
      foreach (letters[k])
      begin
         send_cmd(set_mode_cmd, 1'b1, letters[k], 8'h00);
         zexp = (k == 0);
         sexp = (k == 1 || k == 2);
         repeat (3) @(posedge clk);
         check("zero_mode", {31'h0, zexp}, {31'h0, zero_mode});
         check("span_mode", {31'h0, sexp}, {31'h0, span_mode});
         check("bkg_pulses", 32'(k / 2), 32'(bkg_n));
         new_meas();
         send_cmd(data_request_cmd, 1'b1, 8'h00, 8'h00);
         expect_reply(1'b1, 1'b0, 1'b0);
         drain();
      end
      id = 12'h098;
      send_cmd(data_request_cmd, 1'b1, 8'h00, 8'h00);
      id = 12'h097;
      send_cmd(data_request_cmd, 1'b1, 8'h00, 8'h01);
      send_cmd(set_mode_cmd, 1'b1, XCFR_CH_A, 8'h00);
      long_q = {XCFR_CH_D, XCFR_CH_A};
      repeat (119) long_q.push_back(XCFR_ZERO);
      i_host.send_frame(long_q, 8'h00);
      repeat (60) @(posedge clk);
      reg_write(XCFR_REG_STATUS, 32'hFFFFFFFF);
      reg_read(XCFR_REG_STATUS, 32'h0C04_0000, 32'hFFFF_0700);
      send_cmd(data_request_cmd, 1'b1, 8'h00, 8'h00);
      expect_reply(1'b1, 1'b0, 1'b0);
      send_cmd(data_request_cmd, 1'b1, 8'h00, 8'h00);
      drain();
      print_verdict();
   end
endmodule // testbench
